// ---- hw/casq_top.sv ----
// Module: start and idle sequencer of the async comms adapter
`timescale 1ns/10ps
module casq_top
  import casq_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST,
  input  wire logic              i_STATE_CLK,
  input  wire logic              i_TEST_CLK,
  input  wire logic              i_IO_RESET,
  input  wire logic              i_LOAD_OP,
  input  wire logic [1:0]        i_OP,
  input  wire logic [DEV_W-1:0]  i_DEVICE_NUMBER,
  input  wire logic              i_XFER_DONE,
  input  wire logic              i_INT_ACK,
  input  wire logic              i_INT_REQ,
  input  wire logic              i_LOAD_REQUEST,
  input  wire logic              i_DIAL,
  input  wire logic              i_RECV_END,
  input  wire logic              i_ERROR_SET,
  input  wire logic              i_DLE_SEEN,
  input  wire logic              i_ETX_ETB_SEEN,
  input  wire logic              i_TAPE_EMULATION,
  input  wire logic              i_EXT_MODE_LOAD,
  input  wire logic [3:0]        i_EXT_MODE,
  input  wire logic              i_EXT_STATE_CLR,
  input  wire logic [DATA_W-1:0] i_CHAR_DATA,
  input  wire logic              i_CHAR_VALID,
  output logic                   o_CHAR_READY,
  input  wire logic [DATA_W-1:0] i_STATUS_CODE,
  output logic [STATE_W-1:0]     o_STATE,
  output logic [3:0]             o_MODE,
  output logic [NDEC-1:0]        o_START_LINES,
  output logic [NDEC-1:0]        o_IDLE_LINES,
  output logic [NDEC-1:0]        o_SEND_LINES,
  output logic [NDEC-1:0]        o_RECV_LINES,
  output logic                   o_SEND_STATE1_N,
  output logic                   o_SEND_MODE_IND,
  output logic                   o_HANDSHAKE_DONE,
  output logic                   o_WRITE_READ,
  output logic                   o_STATUS_RDY,
  output logic                   o_IO_BUSY,
  output logic                   o_INTERRUPT,
  output logic                   o_CONNECT_CTRL,
  output logic                   o_HANGUP,
  output logic                   o_FLAG,
  output logic                   o_ERROR,
  output logic                   o_FAULT,
  output logic                   o_GOOD_STATUS,
  output logic                   o_STATUS_CHAR_EMIT,
  output logic                   o_DUAL_END,
  output logic [DATA_W-1:0]      o_STATION_ID,
  output logic [DATA_W-1:0]      o_DATA_REG,
  output logic [DATA_W-1:0]      o_STATUS_OUT
);
  // ============================================================
  // State
  typedef struct packed {
    logic [STATE_W-1:0] state;
    logic [3:0]         mode;
    logic [1:0]         op;
    logic               hs_done;
    logic               wr_rd;
    logic               stat_rdy;
    logic               io_busy;
    logic               intr;
    logic               ccon;
    logic               hangup;
    logic               flag;
    logic               error;
    logic               fault;
    logic               good;
    logic               dual_end;
    logic               sid_pend;
    logic [DATA_W-1:0]  sid;
    logic [DATA_W-1:0]  data;
    logic [DATA_W-1:0]  stat;
  } casq_top_s;
  casq_top_s r_r, r_nxt;
  logic [NDEC-1:0] st_l, id_l;
  logic            hold_count;
  logic            good_status_strobe;
  logic            clr_hs;
  logic            set_int;
  logic            set_srdy;
  logic            take_char;
  logic [DATA_W-1:0] fifo_char;
  logic            fifo_valid;
  casq_fifo_if #(.W(DATA_W)) in_if ();
  casq_fifo_if #(.W(DATA_W)) out_if ();
  // ============================================================
  // Character path: buffered so the channel sees back-pressure
  assign in_if.valid  = i_CHAR_VALID;
  assign in_if.data   = i_CHAR_DATA;
  assign o_CHAR_READY = in_if.ready;
  assign fifo_char    = out_if.data;
  assign fifo_valid   = out_if.valid;
  // Drained only when a handshake is open, so stalls fill the buffer
  assign take_char    = fifo_valid && !r_r.hs_done;
  assign out_if.ready = take_char;
  casq_fifo #(.W(DATA_W), .DEPTH(FDEPTH)) u_fifo (
    .I_CLOCK (I_CLOCK),
    .I_RST   (I_RST),
    .wr      (in_if),
    .rd      (out_if)
  );
  casq_dec u_dec (
    .i_state   (r_r.state),
    .i_mode    (r_r.mode),
    .o_start   (st_l),
    .o_idle    (id_l),
    .o_send    (o_SEND_LINES),
    .o_recv    (o_RECV_LINES),
    .o_send1_n (o_SEND_STATE1_N)
  );
  assign o_START_LINES = st_l;
  assign o_IDLE_LINES  = id_l;
  // ============================================================
  // Sequencer
  always_comb begin
    r_nxt = r_r;
    hold_count = 1'b0;
    good_status_strobe = 1'b0;
    clr_hs = 1'b0;
    set_int = 1'b0;
    set_srdy = 1'b0;
    r_nxt.good = 1'b0;
    if (i_LOAD_OP) begin
      r_nxt.op = i_OP;
      if (i_OP == OP_WRITE || i_OP == OP_WRC)
        r_nxt.wr_rd = 1'b1;
      else
        r_nxt.wr_rd = 1'b0;
      r_nxt.io_busy = 1'b1;
    end
    if (i_STATE_CLK) begin
      r_nxt.state = r_r.state + STATE_W'(1);
      case (1'b1)
        st_l[1]: begin
          clr_hs = 1'b1;
          if (r_r.op != OP_WRC)
            r_nxt.state = ST_6;
        end
        st_l[2]: begin
          if (i_DEVICE_NUMBER != DEV_THREE)
            r_nxt.state = ST_6;
          else if (i_INT_REQ)
            hold_count = 1'b1;
        end
        st_l[3]: begin
          set_int = 1'b1;
          r_nxt.data = DATA_CLR;
        end
        st_l[4]: begin
          if (!r_r.hs_done)
            hold_count = 1'b1;
        end
        st_l[5]: begin
          r_nxt.stat = i_STATUS_CODE;
          clr_hs = 1'b1;
          good_status_strobe = 1'b1;
          r_nxt.mode = MODE_IDLE;
          r_nxt.state = ST_0;
        end
        st_l[6]: begin
          set_srdy = 1'b1;
          if (!r_r.hs_done)
            hold_count = 1'b1;
        end
        st_l[7]: begin
          r_nxt.state = ST_0;
          clr_hs = 1'b1;
        end
        id_l[1]: begin
          set_srdy = 1'b1;
          if (!r_r.hs_done)
            hold_count = 1'b1;
        end
        id_l[2]: clr_hs = 1'b1;
        id_l[3]: begin
          if (!r_r.hs_done || r_r.io_busy)
            hold_count = 1'b1;
        end
        id_l[5]: begin
          clr_hs = 1'b1;
          if (r_r.op != OP_WRC) begin
            r_nxt.ccon = 1'b1;
            r_nxt.state = ST_8;
          end
        end
        id_l[6]: begin
          good_status_strobe = 1'b1;
          if (i_DEVICE_NUMBER == DEV_THREE) begin
            r_nxt.mode = MODE_START;
            r_nxt.state = ST_2;
          end else if (i_DEVICE_NUMBER == DEV_TWO) begin
            r_nxt.hangup = 1'b1;
            if (i_DIAL)
              hold_count = 1'b1;
          end
        end
        id_l[7]: begin
          clr_hs = 1'b1;
          r_nxt.state = ST_0;
          if (i_DEVICE_NUMBER >= DEV_FIVE)
            r_nxt.flag = 1'b1;
        end
        id_l[8]: begin
          r_nxt.data = DATA_CLR;
          if (i_LOAD_REQUEST)
            r_nxt.state = ST_0;
          else if (i_INT_REQ)
            hold_count = 1'b1;
        end
        id_l[10]: begin
          if (i_RECV_END && (r_r.op == OP_READ || r_r.op == OP_RDC)) begin
            r_nxt.mode = MODE_RECV;
            r_nxt.state = ST_6;
          end else
            r_nxt.state = ST_6;
        end
        id_l[14]: begin
          r_nxt.mode = MODE_SEND;
          r_nxt.state = ST_0;
        end
        default: ;
      endcase
      // Any hold (interrupt, handshake, busy or dial) freezes the state unless the mode changes in the same step
      if (hold_count && r_nxt.mode == r_r.mode)
        r_nxt.state = r_r.state;
    end
    if (i_EXT_MODE_LOAD)
      r_nxt.mode = i_EXT_MODE;
    if (i_EXT_STATE_CLR)
      r_nxt.state = ST_0;
    // Read-control station id fetch
    if (i_LOAD_OP && i_OP == OP_RDC && i_DEVICE_NUMBER != DEV_ZERO) begin
      r_nxt.sid_pend = 1'b1;
      set_int = 1'b1;
    end
    if (i_INT_ACK)
      r_nxt.intr = 1'b0;
    if (set_int) begin
      r_nxt.intr = 1'b1;
      clr_hs = 1'b1;
    end
    if (clr_hs) begin
      r_nxt.hs_done = 1'b0;
      r_nxt.stat_rdy = 1'b0;
    end
    if (take_char) begin
      r_nxt.data = fifo_char;
      if (r_r.sid_pend) begin
        r_nxt.sid = fifo_char;
        r_nxt.sid_pend = 1'b0;
      end
    end
    // Completion wins over a clear in the same cycle
    if (take_char && i_XFER_DONE)
      r_nxt.hs_done = 1'b1;
    if (set_srdy) begin
      r_nxt.stat_rdy = 1'b1;
      r_nxt.io_busy = 1'b0;
    end
    if (i_ERROR_SET)
      r_nxt.error = 1'b1;
    if (good_status_strobe) begin
      r_nxt.good = 1'b1;
      r_nxt.flag = 1'b0;
      r_nxt.error = i_ERROR_SET;
      r_nxt.fault = 1'b1;
    end
    r_nxt.dual_end = i_DLE_SEEN ||
                     (!i_TAPE_EMULATION && i_ETX_ETB_SEEN);
    if (i_IO_RESET)
      r_nxt = '0;
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RST)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end
  // ============================================================
  // Outputs
  assign o_STATE            = r_r.state;
  assign o_MODE             = r_r.mode;
  assign o_SEND_MODE_IND    = (r_r.mode == MODE_SEND);
  assign o_HANDSHAKE_DONE   = r_r.hs_done;
  assign o_WRITE_READ       = r_r.wr_rd;
  assign o_STATUS_RDY       = r_r.stat_rdy;
  assign o_IO_BUSY          = r_r.io_busy;
  assign o_INTERRUPT        = r_r.intr;
  assign o_CONNECT_CTRL     = r_r.ccon;
  assign o_HANGUP           = r_r.hangup;
  assign o_FLAG             = r_r.flag;
  assign o_ERROR            = r_r.error;
  assign o_FAULT            = r_r.fault;
  assign o_GOOD_STATUS      = r_r.good;
  // Combinational, so it follows receive end without a cycle's lag
  assign o_STATUS_CHAR_EMIT = r_r.error && i_RECV_END &&
                              i_TAPE_EMULATION;
  assign o_DUAL_END         = r_r.dual_end;
  assign o_STATION_ID       = r_r.sid;
  assign o_DATA_REG         = r_r.data;
  assign o_STATUS_OUT       = r_r.stat;
  // ============================================================
  // Checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST || i_IO_RESET || i_EXT_STATE_CLR ||
                       i_EXT_MODE_LOAD);
  a_start1_jump: assert property (
    st_l[1] && i_STATE_CLK && r_r.op != OP_WRC |=> r_r.state == ST_6
    && !r_r.hs_done) else $error("start 1 did not jump to 6");
  a_start2_jump: assert property (
    st_l[2] && i_STATE_CLK && i_DEVICE_NUMBER != DEV_THREE
    |=> r_r.state == ST_6) else $error("start 2 did not jump to 6");
  a_idle5_conn: assert property (
    id_l[5] && i_STATE_CLK && r_r.op != OP_WRC |=> r_r.ccon
    && r_r.state == ST_8) else $error("idle 5 connect or jump missing");
  a_idle6_start: assert property (
    id_l[6] && i_STATE_CLK && i_DEVICE_NUMBER == DEV_THREE
    |=> st_l[2]) else $error("idle 6 did not enter start 2");
  a_idle7_clear: assert property (
    id_l[7] && i_STATE_CLK |=> r_r.state == ST_0 && !r_r.hs_done)
    else $error("idle 7 clear failed");
  a_idle8_hold: assert property (
    id_l[8] && i_STATE_CLK && i_INT_REQ && !i_LOAD_REQUEST |=> id_l[8]
    && r_r.data == DATA_CLR) else $error("idle 8 hold failed");
  a_idle10_recv: assert property (
    id_l[10] && i_STATE_CLK && i_RECV_END && r_r.op == OP_RDC
    |=> o_RECV_LINES[6]) else $error("idle 10 did not enter receive 6");
  a_count_step: assert property (
    i_STATE_CLK && !i_LOAD_OP && (st_l[0] || id_l[0] || id_l[4])
    |=> r_r.state == $past(r_r.state) + STATE_W'(1))
    else $error("state counter did not step");
  a_srdy_busy: assert property (
    r_r.stat_rdy && !$past(r_r.stat_rdy) && !$past(i_LOAD_OP)
    |-> !r_r.io_busy) else $error("io busy left set with status ready");
  a_good_fault: assert property (
    good_status_strobe |=> r_r.fault && !r_r.flag)
    else $error("good status did not set fault");
  a_emit_only: assert property (
    o_STATUS_CHAR_EMIT |-> i_TAPE_EMULATION && r_r.error && i_RECV_END)
    else $error("status character outside tape case");
  c_start_idle: cover property (st_l[5] && i_STATE_CLK ##1 id_l[0]);
  c_idle_recv: cover property (id_l[10] ##1 o_RECV_LINES[6]);
  c_sid_load: cover property (r_r.sid_pend ##[1:20] !r_r.sid_pend);
  c_hold8: cover property (id_l[8] && i_INT_REQ && i_STATE_CLK);
endmodule

// ---- common/casq_pkg.sv ----
// Package: shared constants and types of the adapter start/idle sequencer
package casq_pkg;
  // ============================================================
  // Widths
  localparam int STATE_W = 4;
  localparam int DEV_W   = 3;
  localparam int DATA_W  = 8;
  localparam int NDEC    = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [DEV_W-1:0] DEV_ZERO = 3'h0;
  localparam logic [DEV_W-1:0] DEV_TWO   = 3'h2;
  localparam logic [DEV_W-1:0] DEV_THREE = 3'h3;
  localparam logic [DEV_W-1:0] DEV_FIVE  = 3'h5;
  // ============================================================
  // States within the modes
  localparam logic [STATE_W-1:0] ST_0  = 4'h0;
  localparam logic [STATE_W-1:0] ST_1  = 4'h1;
  localparam logic [STATE_W-1:0] ST_2  = 4'h2;
  localparam logic [STATE_W-1:0] ST_3  = 4'h3;
  localparam logic [STATE_W-1:0] ST_4  = 4'h4;
  localparam logic [STATE_W-1:0] ST_5  = 4'h5;
  localparam logic [STATE_W-1:0] ST_6  = 4'h6;
  localparam logic [STATE_W-1:0] ST_7  = 4'h7;
  localparam logic [STATE_W-1:0] ST_8  = 4'h8;
  localparam logic [STATE_W-1:0] ST_10 = 4'ha;
  localparam logic [STATE_W-1:0] ST_14 = 4'he;
  localparam logic [DATA_W-1:0]  DATA_CLR = 8'h00;
  // ============================================================
  // Operation codes
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_RDC   = 2'h1,
    OP_WRITE = 2'h2,
    OP_WRC   = 2'h3
  } casq_op_e;
  // Modes, one-hot
  typedef enum logic [3:0] {
    MODE_START = 4'h1,
    MODE_IDLE  = 4'h2,
    MODE_SEND  = 4'h4,
    MODE_RECV  = 4'h8
  } casq_mode_e;
  // Binary to one-hot decimal state lines
  function automatic logic [NDEC-1:0] casq_dec(
    input logic [STATE_W-1:0] s, input logic en);
    casq_dec = en ? (16'h0001 << s) : 16'h0000;
  endfunction
endpackage

// ---- common/casq_fifo_if.sv ----
// Interface: valid/ready stream between adapter modules
`timescale 1ns/10ps
interface casq_fifo_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ---- hw/casq_fifo.sv ----
// Module: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module casq_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic I_CLOCK,
  input  wire logic I_RST,
  casq_fifo_if.dst  wr,
  casq_fifo_if.src  rd
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } casq_fifo_s;
  casq_fifo_s q_r, q_nxt;
  logic push, pop;
  assign wr.ready = (q_r.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (q_r.cnt != '0);
  assign rd.data  = q_r.mem[q_r.rp];
  assign push = wr.valid && wr.ready;
  assign pop  = rd.valid && rd.ready;
  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = wr.data;
      q_nxt.wp = (q_r.wp == AW'(DEPTH-1)) ? '0 : q_r.wp + AW'(1);
    end
    if (pop)
      q_nxt.rp = (q_r.rp == AW'(DEPTH-1)) ? '0 : q_r.rp + AW'(1);
    q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RST)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end
  a_fifo_no_over: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    q_r.cnt <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
  c_fifo_full: cover property (@(posedge I_CLOCK) disable iff (I_RST)
    !wr.ready);
endmodule

// ---- hw/casq_dec.sv ----
// Module: binary-to-decimal state decoders for every mode
`timescale 1ns/10ps
module casq_dec
  import casq_pkg::*;
(
  input  wire logic [STATE_W-1:0] i_state,
  input  wire logic [3:0]         i_mode,
  output logic      [NDEC-1:0]    o_start,
  output logic      [NDEC-1:0]    o_idle,
  output logic      [NDEC-1:0]    o_send,
  output logic      [NDEC-1:0]    o_recv,
  output logic                    o_send1_n
);
  assign o_start = casq_dec(i_state, i_mode == MODE_START);
  assign o_idle  = casq_dec(i_state, i_mode == MODE_IDLE);
  assign o_send  = casq_dec(i_state, i_mode == MODE_SEND);
  assign o_recv  = casq_dec(i_state, i_mode == MODE_RECV);
  assign o_send1_n = ~o_send[1];
endmodule

// ---- testbench/casq_chan_model.sv ----
// Processor channel model: feeds characters and answers interrupts
`timescale 1ns/10ps
module casq_chan_model
  import casq_pkg::*;
(
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST,
  input  wire logic              i_interrupt,
  input  wire logic              i_ready,
  input  wire logic              i_push,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic [3:0]        i_delay,
  output logic                   o_valid,
  output logic [DATA_W-1:0]      o_data,
  output logic                   o_int_ack
);
  // ========
  // One character in flight at a time
  logic       irq_d_r;
  logic       irq_pend_r;
  logic       ack_pend_r;
  logic [3:0] cnt_r;
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_valid    <= 1'b0;
      o_data     <= 8'ha5;
      o_int_ack  <= 1'b0;
      irq_d_r    <= 1'b0;
      irq_pend_r <= 1'b0;
      ack_pend_r <= 1'b0;
      cnt_r      <= 4'h0;
    end else begin
      irq_d_r   <= i_interrupt;
      o_int_ack <= 1'b0;
      if (i_interrupt && !irq_d_r) begin
        irq_pend_r <= 1'b1;
        cnt_r      <= i_delay;
      end else if (cnt_r != 4'h0) begin
        // Slow answer keeps the adapter waiting
        cnt_r <= cnt_r - 4'h1;
      end
      if (o_valid && i_ready) begin
        o_valid    <= 1'b0;
        // Released line must not keep the last value
        o_data     <= ~o_data;
        o_int_ack  <= ack_pend_r;
        ack_pend_r <= 1'b0;
      end else if (!o_valid && irq_pend_r && cnt_r == 4'h0) begin
        o_valid    <= 1'b1;
        o_data     <= i_data;
        irq_pend_r <= 1'b0;
        ack_pend_r <= 1'b1;
      end else if (!o_valid && i_push) begin
        o_valid <= 1'b1;
        o_data  <= i_data;
      end
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Testbench: directed sequences for the start/idle sequencer
`timescale 1ns/10ps
module tb;
  import casq_pkg::*;
  // ========
  // Stimulus and observation
  logic               clk, rst, stc, ldop, iack, ireq, ldrq, dial, rend;
  logic               errs, dle, etx, tape, mld, sclr, xfer, cval, crdy;
  logic               push, s1n, sind, hs, wr, srdy, busy, intr, conn;
  logic               hang, flag, err, flt, good, emit, dual, iorst;
  logic [1:0]         op;
  logic [DEV_W-1:0]   dev;
  logic [3:0]         mode_in, mode, dly;
  logic [STATE_W-1:0] st;
  logic [DATA_W-1:0]  cdat, pdat, dreg, sid, stout;
  logic [NDEC-1:0]    sl, il, tl, rl;
  int                 err_count, cmp_count;

  casq_top #(.FDEPTH(FIFO_DEPTH)) casq_top_i (
    .I_CLOCK(clk), .I_RST(rst), .i_STATE_CLK(stc), .i_TEST_CLK(1'b0),
    .i_IO_RESET(iorst), .i_LOAD_OP(ldop), .i_OP(op),
    .i_DEVICE_NUMBER(dev), .i_XFER_DONE(xfer), .i_INT_ACK(iack),
    .i_INT_REQ(ireq), .i_LOAD_REQUEST(ldrq), .i_DIAL(dial),
    .i_RECV_END(rend), .i_ERROR_SET(errs), .i_DLE_SEEN(dle),
    .i_ETX_ETB_SEEN(etx), .i_TAPE_EMULATION(tape),
    .i_EXT_MODE_LOAD(mld), .i_EXT_MODE(mode_in), .i_EXT_STATE_CLR(sclr),
    .i_CHAR_DATA(cdat), .i_CHAR_VALID(cval), .o_CHAR_READY(crdy),
    .i_STATUS_CODE(8'h96), .o_STATE(st), .o_MODE(mode),
    .o_START_LINES(sl), .o_IDLE_LINES(il), .o_SEND_LINES(tl),
    .o_RECV_LINES(rl), .o_SEND_STATE1_N(s1n), .o_SEND_MODE_IND(sind),
    .o_HANDSHAKE_DONE(hs), .o_WRITE_READ(wr), .o_STATUS_RDY(srdy),
    .o_IO_BUSY(busy), .o_INTERRUPT(intr), .o_CONNECT_CTRL(conn),
    .o_HANGUP(hang), .o_FLAG(flag), .o_ERROR(err), .o_FAULT(flt),
    .o_GOOD_STATUS(good), .o_STATUS_CHAR_EMIT(emit), .o_DUAL_END(dual),
    .o_STATION_ID(sid), .o_DATA_REG(dreg), .o_STATUS_OUT(stout));

  casq_chan_model casq_chan_model_i (.I_CLOCK(clk), .I_RST(rst),
    .i_interrupt(intr), .i_ready(crdy), .i_push(push), .i_data(pdat),
    .i_delay(dly), .o_valid(cval), .o_data(cdat), .o_int_ack(iack));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ========
  // Access tasks
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step();
    stc <= 1'b1;
    @(posedge clk);
    stc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic load_op(input logic [1:0] o);
    op   <= o;
    ldop <= 1'b1;
    @(posedge clk);
    ldop <= 1'b0;
    @(posedge clk);
  endtask
  task automatic set_mode(input logic [3:0] m);
    mode_in <= m;
    mld     <= 1'b1;
    sclr    <= 1'b1;
    @(posedge clk);
    mld  <= 1'b0;
    sclr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send_char(input logic [7:0] d);
    pdat <= d;
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_hs();
    for (int k = 0; k < 40 && hs !== 1'b1; k++) @(posedge clk);
    if (hs !== 1'b1) begin
      chk("handshake_wait", 1'b1, hs);
      final_report();
    end
  endtask
  // Idle 0 to 5; fill optionally stuffs the FIFO while it is held
  task automatic idle_to5(input logic fill);
    set_mode(MODE_IDLE);
    step();
    send_char(8'h21);
    wait_hs();
    if (fill) begin
      xfer <= 1'b0;
      for (int i = 0; i < 9; i++) send_char(8'h10 + 8'(i));
      chk("fifo_full", 1'b0, crdy);
      chk("char_stalled", 1'b1, cval);
    end
    step();
    step();
    if (fill) begin
      for (int k = 0; k < 60 && dreg !== 8'h18; k++) @(posedge clk);
      chk("drained_char", 8'h18, dreg);
      chk("fifo_empty", 1'b1, crdy);
      xfer <= 1'b1;
    end
    send_char(8'h22);
    wait_hs();
    step();
    step();
  endtask

  // ========
  // Main sequence
  initial begin
    {stc, ldop, ireq, ldrq, dial, rend, errs, dle, etx, tape} = '0;
    {mld, sclr, push, iorst} = '0;
    rst = 1'b1;
    xfer = 1'b1;
    op = 2'h0;
    dev = DEV_ZERO;
    mode_in = 4'h0;
    pdat = 8'h00;
    dly = 4'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset_mode", 4'h0, mode);
    chk("reset_ready", 1'b1, crdy);
    for (int i = 0; i < 4; i++) begin
      load_op(i[1:0]);
      chk("write_read", i[1], wr);
    end
    dev  <= 3'h1;
    pdat <= 8'hc3;
    load_op(OP_RDC);
    chk("fetch_interrupt", 1'b1, intr);
    wait_hs();
    repeat (2) @(posedge clk);
    chk("station_id", 8'hc3, sid);
    chk("interrupt_acked", 1'b0, intr);
    errs <= 1'b1;
    @(posedge clk);
    errs <= 1'b0;
    rend <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      {dle, etx, tape} <= i[2:0];
      repeat (2) @(posedge clk);
      chk("status_char", i[0], emit);
      chk("dual_end", i[2] | (i[1] & ~i[0]), dual);
    end
    rend <= 1'b0;
    @(posedge clk);
    chk("status_char_off", 1'b0, emit);
    {dle, etx, tape} <= 3'h0;
    // Slow answer so the wait in start 4 is really seen
    dly  <= 4'h6;
    dev  <= DEV_THREE;
    pdat <= 8'h44;
    load_op(OP_WRC);
    set_mode(MODE_START);
    chk("start_lines", 16'h0001, sl);
    chk("idle_lines", 16'h0000, il);
    step();
    chk("state_advance", ST_1, st);
    step();
    chk("start2", ST_2, st);
    chk("hs_cleared", 1'b0, hs);
    chk("status_rdy_clr", 1'b0, srdy);
    ireq <= 1'b1;
    step();
    chk("start2_hold", ST_2, st);
    ireq <= 1'b0;
    step();
    step();
    chk("start4", ST_4, st);
    chk("interrupt_set", 1'b1, intr);
    chk("data_cleared", DATA_CLR, dreg);
    step();
    chk("start4_hold", ST_4, st);
    wait_hs();
    step();
    step();
    chk("idle_entry", MODE_IDLE, mode);
    chk("idle_state0", ST_0, st);
    chk("status_code", 8'h96, stout);
    for (int k = 0; k < 3 && good !== 1'b1; k++) @(posedge clk);
    chk("good_status", 1'b1, good);
    @(posedge clk);
    chk("good_pulse_end", 1'b0, good);
    chk("error_reset", 1'b0, err);
    chk("fault_set", 1'b1, flt);
    dly <= 4'h0;
    idle_to5(1'b1);
    step();
    chk("idle5_wrc", ST_6, st);
    chk("no_connect", 1'b0, conn);
    dev  <= DEV_TWO;
    dial <= 1'b1;
    step();
    chk("idle6_dial_hold", ST_6, st);
    chk("hangup", 1'b1, hang);
    dial <= 1'b0;
    dev  <= DEV_FIVE;
    step();
    step();
    chk("idle7_clear", ST_0, st);
    chk("flag_set", 1'b1, flag);
    dev <= DEV_ZERO;
    load_op(OP_RDC);
    idle_to5(1'b0);
    step();
    chk("idle5_jump", ST_8, st);
    chk("connect_set", 1'b1, conn);
    ireq <= 1'b1;
    step();
    chk("idle8_hold", ST_8, st);
    chk("idle8_data_clr", DATA_CLR, dreg);
    ireq <= 1'b0;
    ldrq <= 1'b1;
    step();
    chk("idle8_load_request", ST_0, st);
    ldrq <= 1'b0;
    idle_to5(1'b0);
    repeat (3) step();
    rend <= 1'b1;
    step();
    chk("recv_mode", MODE_RECV, mode);
    chk("recv_lines", 16'h0040, rl);
    rend <= 1'b0;
    load_op(OP_READ);
    set_mode(MODE_START);
    step();
    step();
    chk("start1_jump", ST_6, st);
    step();
    chk("status_ready", 1'b1, srdy);
    chk("io_busy_clr", 1'b0, busy);
    set_mode(MODE_SEND);
    chk("send_ind", 1'b1, sind);
    chk("send_lines", 16'h0001, tl);
    chk("send1_n_high", 1'b1, s1n);
    step();
    chk("send1_n_low", 1'b0, s1n);
    chk("start_lines_off", 16'h0000, sl);
    // Idle 10 without receive end falls back to idle 6
    idle_to5(1'b0);
    repeat (3) step();
    step();
    chk("idle10_back", ST_6, st);
    chk("idle10_mode", MODE_IDLE, mode);
    dev <= DEV_THREE;
    step();
    chk("idle6_to_start2", 16'h0004, sl);
    chk("flag_reset", 1'b0, flag);
    dev <= 3'h1;
    step();
    chk("start2_jump", ST_6, st);
    // I/O reset in mid-run clears every sequencer register to zero, mode included; the FIFO keeps its contents
    iorst <= 1'b1;
    @(posedge clk);
    iorst <= 1'b0;
    @(posedge clk);
    chk("io_reset_mode", 4'h0, mode);
    chk("io_reset_conn", 1'b0, conn);
    final_report();
  end
endmodule
